/* File: srec_pkg.sv */
// Purpose: Shared constants and types for the load-record parser.
// Assumes: Records arrive as 8-bit ASCII characters.
// Notes:   Every character code and limit the parser uses is named here.

package srec_pkg;

  // ----------------------------------------
  // Character codes
  // ----------------------------------------
  localparam logic [7:0] ASC_S    = 8'h53; // Record type letter
  localparam logic [7:0] ASC_CR   = 8'h0d; // Carriage return
  localparam logic [7:0] ASC_LF   = 8'h0a; // Line feed
  localparam logic [7:0] ASC_NUL  = 8'h00; // Null
  localparam logic [7:0] ASC_0    = 8'h30; // Digit zero
  localparam logic [7:0] ASC_1    = 8'h31; // Data record digit
  localparam logic [7:0] ASC_9    = 8'h39; // End record digit
  localparam logic [7:0] ASC_UA   = 8'h41; // Upper case A
  localparam logic [7:0] ASC_UF   = 8'h46; // Upper case F
  localparam logic [7:0] ASC_LA   = 8'h61; // Lower case a
  localparam logic [7:0] ASC_LF_F = 8'h66; // Lower case f

  // ----------------------------------------
  // Record layout and limits
  // ----------------------------------------
  localparam int         LOAD_AW  = 16;    // Two-byte load address
  localparam logic [7:0] MIN_LEN  = 8'h03; // Address pair plus checksum
  localparam logic [7:0] SUM_GOOD = 8'hff; // Sum of all bytes plus checksum
  localparam logic [7:0] LAST_TWO = 8'h02; // Pairs left when checksum is next

  // ----------------------------------------
  // Parser states and error causes
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_HUNT, ST_TYPE, ST_LEN, ST_ADDR, ST_DATA, ST_SUM, ST_REPLAY, ST_DONE
  } state_t;

  typedef enum logic [2:0] {
    ERR_NONE, ERR_CHAR, ERR_SHORT, ERR_LEN, ERR_SUM, ERR_TYPE
  } err_t;

endpackage : srec_pkg

/* File: rec_mem.sv */
// Purpose: Holds the data bytes of one record until its checksum is known.
// Assumes: One write port, one read port, same clock.
// Notes:   Read data come out of a register, one cycle after the address.

`timescale 1ns/1ps
`default_nettype none

module rec_mem #(
  parameter int DW = 8, // Byte width
  parameter int AW = 8  // Index width
) (
  // Clock
  input  wire logic          core_clk,
  // Write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read side
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW]; // Record byte store

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Write when asked, read every cycle into a register
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : rec_mem

`default_nettype wire

/* File: srecord_line_parser.sv */
// Purpose: Parses hex load records from a character link into byte writes.
// Assumes: Characters and write handshakes are synchronous to core_clk.
// Notes:   A record's bytes are held until its checksum passes, then replayed.
//
// How it works
// - High nibble character first, then low nibble
// - Fields: type, length, address, data, checksum
// - Type is letter S then digit
// - Length counts pairs after the length field
// - Address field carries the load address
// - Data length follows from the length count
// - Checksum is complemented low byte of sum
// - CR, LF, NUL end records, are discarded
// - Skip leading characters before the S letter
// - Length and checksum together verify each record
// - Accept only S1 and S9 types; S0 is skipped before the first S1
// - Ignore input before first S1, then S1 or S9 only
// - S9 has no data, may give start address

`timescale 1ns/1ps
`default_nettype none

module srecord_line_parser
  import srec_pkg::*;
#(
  parameter int MEM_AW = 8 // Index width of the record store
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  // Character link
  input  wire logic               char_valid,
  input  wire logic [7:0]         char_data,
  output var  logic               char_ready,
  // Memory write port
  output var  logic               wr_valid,
  output var  logic [LOAD_AW-1:0] wr_addr,
  output var  logic [7:0]         wr_data,
  input  wire logic               wr_ready,
  // Control
  input  wire logic               err_clear,
  input  wire logic               load_restart,
  // Status
  output var  logic               err_flag,
  output var  err_t               err_cause,
  output var  logic               rec_ok,
  output var  logic               load_done,
  output var  logic [LOAD_AW-1:0] start_addr
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Decode a hex character to {valid, nibble}
  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (c >= ASC_0 && c <= ASC_9) begin
      d = c - ASC_0;
      return {1'b1, d[3:0]};
    end else if (c >= ASC_UA && c <= ASC_UF) begin
      d = c - ASC_UA + 8'h0a;
      return {1'b1, d[3:0]};
    end else if (c >= ASC_LA && c <= ASC_LF_F) begin
      d = c - ASC_LA + 8'h0a;
      return {1'b1, d[3:0]};
    end
    return 5'h00;
  endfunction : hex_nib

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic              rst_meta;  // Reset synchroniser, first stage
  logic              rst_n;     // Synchronised reset
  state_t            state;     // Parser state
  logic              seen_s1;   // A data record has started the load
  logic              is_end;    // Current record is the end record
  logic              hi_nib;    // High nibble already held
  logic [3:0]        hold_nib;  // Held high nibble
  logic [7:0]        remain;    // Pairs still to come in this record
  logic [7:0]        sum;       // Running byte sum
  logic              addr_cnt;  // First address byte taken
  logic [LOAD_AW-1:0] rec_addr; // Record load address
  logic [7:0]        dcnt;      // Data bytes stored
  logic [7:0]        rd_idx;    // Next byte to read back
  logic [7:0]        push_idx;  // Next byte to enter the buffer
  logic              rd_pend;   // A read is in flight
  logic [7:0]        rdata;     // Store read data
  logic              sk_valid;  // Second buffer entry full
  logic [LOAD_AW-1:0] sk_addr;  // Second entry address
  logic [7:0]        sk_data;   // Second entry data
  logic              take;      // Character accepted this cycle
  logic [4:0]        hx;        // Decoded character
  logic              is_term;   // Character is a terminator
  logic              in_field;  // State consumes hex pairs
  logic              got_byte;  // Low nibble completes a byte
  logic [7:0]        cur_byte;  // Byte just completed
  logic              err_now;   // Error detected this cycle
  err_t              err_code;  // Cause of that error
  logic [1:0]        fill;      // Buffer entries plus read in flight
  logic              rd_go;     // Issue a read this cycle
  logic              pop;       // Front entry leaves

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  // Two stages so release is clean against core_clk
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------
  // Character decode
  // ----------------------------------------
  assign take     = char_valid & char_ready;
  assign hx       = hex_nib(char_data);
  assign is_term  = (char_data == ASC_CR) | (char_data == ASC_LF) |
                    (char_data == ASC_NUL);
  assign in_field = (state == ST_LEN) | (state == ST_ADDR) |
                    (state == ST_DATA) | (state == ST_SUM);
  assign got_byte = take & in_field & hx[4] & hi_nib;
  assign cur_byte = {hold_nib, hx[3:0]};

  // Error detection, first cause wins
  always_comb begin
    err_now  = 1'b0;
    err_code = ERR_NONE;
    if (take && in_field && (is_term || char_data == ASC_S)) begin
      err_now  = 1'b1; // Record cut before its count ran out
      err_code = ERR_SHORT;
    end else if (take && in_field && !hx[4]) begin
      err_now  = 1'b1; // Not a hex digit
      err_code = ERR_CHAR;
    end else if (got_byte && state == ST_LEN &&
                 (cur_byte < MIN_LEN || (is_end && cur_byte != MIN_LEN))) begin
      err_now  = 1'b1; // Too short, or end record with data
      err_code = ERR_LEN;
    end else if (got_byte && state == ST_SUM &&
                 (8'(sum + cur_byte) != SUM_GOOD)) begin
      err_now  = 1'b1; // Checksum mismatch
      err_code = ERR_SUM;
    end else if (take && state == ST_TYPE && seen_s1 &&
                 char_data != ASC_1 && char_data != ASC_9) begin
      err_now  = 1'b1; // Only data records until the end record
      err_code = ERR_TYPE;
    end
  end

  // ----------------------------------------
  // Nibble pairing
  // ----------------------------------------
  // High nibble first, low nibble completes the byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_nib   <= 1'b0;
      hold_nib <= 4'h0;
    end else if (!in_field || err_now) begin
      hi_nib <= 1'b0;
    end else if (take) begin
      hi_nib   <= ~hi_nib;
      hold_nib <= hx[3:0];
    end
  end

  // ----------------------------------------
  // Record state machine
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_HUNT;
      seen_s1    <= 1'b0;
      is_end     <= 1'b0;
      remain     <= 8'h00;
      sum        <= 8'h00;
      addr_cnt   <= 1'b0;
      rec_addr   <= 16'h0000;
      dcnt       <= 8'h00;
      char_ready <= 1'b1;
      rec_ok     <= 1'b0;
      load_done  <= 1'b0;
      start_addr <= 16'h0000;
    end else begin
      rec_ok <= 1'b0;
      if (load_restart) begin
        // Start a fresh load
        state      <= ST_HUNT;
        seen_s1    <= 1'b0;
        load_done  <= 1'b0;
        char_ready <= 1'b1;
      end else begin
        case (state)
          ST_HUNT: begin
            // Skip terminators and leading fields until S
            if (take && char_data == ASC_S) begin
              state <= ST_TYPE;
            end
          end
          ST_TYPE: begin
            if (take) begin
              if (char_data == ASC_1) begin
                state   <= ST_LEN;
                is_end  <= 1'b0;
                seen_s1 <= 1'b1;
              end else if (char_data == ASC_9 && seen_s1) begin
                state  <= ST_LEN;
                is_end <= 1'b1;
              end else begin
                state <= ST_HUNT; // Header or early record is ignored
              end
            end
          end
          ST_REPLAY: begin
            // Leave once the last byte entered the buffer
            if (rd_pend && push_idx == 8'(dcnt - 8'h01)) begin
              state      <= ST_HUNT;
              char_ready <= 1'b1;
            end
          end
          ST_DONE: begin
            state <= ST_DONE; // Input after the end record is dropped
          end
          default: begin
            if (err_now) begin
              state <= ST_HUNT;
            end else if (got_byte) begin
              case (state)
                ST_LEN: begin
                  remain   <= cur_byte;
                  sum      <= cur_byte;
                  addr_cnt <= 1'b0;
                  dcnt     <= 8'h00;
                  state    <= ST_ADDR;
                end
                ST_ADDR: begin
                  rec_addr <= {rec_addr[7:0], cur_byte};
                  sum      <= 8'(sum + cur_byte);
                  remain   <= 8'(remain - 8'h01);
                  addr_cnt <= 1'b1;
                  if (addr_cnt) begin
                    state <= (remain == LAST_TWO) ? ST_SUM : ST_DATA;
                  end
                end
                ST_DATA: begin
                  sum    <= 8'(sum + cur_byte);
                  remain <= 8'(remain - 8'h01);
                  dcnt   <= 8'(dcnt + 8'h01);
                  if (remain == LAST_TWO) begin
                    state <= ST_SUM;
                  end
                end
                default: begin
                  // Checksum passed
                  if (is_end) begin
                    state      <= ST_DONE;
                    load_done  <= 1'b1;
                    start_addr <= rec_addr;
                  end else if (dcnt == 8'h00) begin
                    state  <= ST_HUNT;
                    rec_ok <= 1'b1;
                  end else begin
                    state      <= ST_REPLAY;
                    char_ready <= 1'b0;
                    rec_ok     <= 1'b1;
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Error flag
  // ----------------------------------------
  // Sticky; a new error wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_flag  <= 1'b0;
      err_cause <= ERR_NONE;
    end else if (err_now) begin
      err_flag  <= 1'b1;
      err_cause <= err_code;
    end else if (err_clear) begin
      err_flag  <= 1'b0;
      err_cause <= ERR_NONE;
    end
  end

  // ----------------------------------------
  // Record store
  // ----------------------------------------
  rec_mem #(
    .DW (8),
    .AW (MEM_AW)
  ) u_store (
    .core_clk (core_clk),
    .we       (got_byte && state == ST_DATA && !err_now),
    .waddr    (dcnt[MEM_AW-1:0]),
    .wdata    (cur_byte),
    .raddr    (rd_idx[MEM_AW-1:0]),
    .rdata    (rdata)
  );

  // ----------------------------------------
  // Replay reads
  // ----------------------------------------
  assign pop   = wr_valid & wr_ready;
  assign fill  = 2'({1'b0, wr_valid} + {1'b0, sk_valid} + {1'b0, rd_pend});
  assign rd_go = (state == ST_REPLAY) && (rd_idx != dcnt) && (fill < 2'd2);

  // Read only while the buffer has room, so a stall loses nothing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_idx   <= 8'h00;
      push_idx <= 8'h00;
      rd_pend  <= 1'b0;
    end else if (state != ST_REPLAY) begin
      rd_idx   <= 8'h00;
      push_idx <= 8'h00;
      rd_pend  <= 1'b0;
    end else begin
      rd_pend <= rd_go;
      if (rd_go) begin
        rd_idx <= 8'(rd_idx + 8'h01);
      end
      if (rd_pend) begin
        push_idx <= 8'(push_idx + 8'h01);
      end
    end
  end

  // ----------------------------------------
  // Two-entry write buffer
  // ----------------------------------------
  // Front entry drives the port; second entry catches a stalled push
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid <= 1'b0;
      wr_addr  <= 16'h0000;
      wr_data  <= 8'h00;
      sk_valid <= 1'b0;
      sk_addr  <= 16'h0000;
      sk_data  <= 8'h00;
    end else if (!wr_valid || pop) begin
      if (sk_valid) begin
        wr_valid <= 1'b1;
        wr_addr  <= sk_addr;
        wr_data  <= sk_data;
        sk_valid <= 1'b0;
      end else begin
        wr_valid <= rd_pend;
        wr_addr  <= LOAD_AW'(rec_addr + {8'h00, push_idx});
        wr_data  <= rdata;
      end
    end else if (rd_pend) begin
      sk_valid <= 1'b1;
      sk_addr  <= LOAD_AW'(rec_addr + {8'h00, push_idx});
      sk_data  <= rdata;
    end
  end

endmodule : srecord_line_parser

`default_nettype wire

/* File: srec_chk_sva.sv */
// Purpose: Port-level checks for the load-record parser.
// Assumes: Sees only the parser's top ports; one clock domain.
// Notes:   Attached to every parser instance by the bind below.
`timescale 1ns/1ps
`default_nettype none
module srec_chk
  import srec_pkg::*;
(
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               arst_n,
  // Character link
  input wire logic               char_valid,
  input wire logic [7:0]         char_data,
  input wire logic               char_ready,
  // Memory write port
  input wire logic               wr_valid,
  input wire logic [LOAD_AW-1:0] wr_addr,
  input wire logic [7:0]         wr_data,
  input wire logic               wr_ready,
  // Control and status
  input wire logic               err_clear,
  input wire logic               load_restart,
  input wire logic               err_flag,
  input wire err_t               err_cause,
  input wire logic               rec_ok,
  input wire logic               load_done,
  input wire logic [LOAD_AW-1:0] start_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // A stalled write keeps its address and data
  write_hold_a: assert property (
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("write changed before it was taken");
  // Error flag is sticky until cleared
  err_keep_a: assert property (
    err_flag && !err_clear |=> err_flag) else $error("error flag dropped");
  // A raised error names a cause and never passes the record
  err_cause_a: assert property (
    $rose(err_flag) |-> err_cause != ERR_NONE && !rec_ok) else $error("bad error report");
  // Record pass is a single-cycle pulse
  ok_pulse_a: assert property (
    rec_ok |=> !rec_ok) else $error("record pass pulse too long");
  // The link closes only when a passed record starts its replay
  ok_stall_a: assert property (
    $fell(char_ready) |-> rec_ok) else $error("link closed without a passed record");
  // The link reopens within a bounded time
  ready_back_a: assert property (
    $fell(char_ready) |-> ##[1:1000] char_ready) else $error("link stuck closed");
  // End of load holds along with its start address
  done_keep_a: assert property (
    load_done && !load_restart |=> load_done && $stable(start_addr))
    else $error("load end state lost");
  // Nothing new is written once the load has ended
  done_quiet_a: assert property (
    load_done && !wr_valid |=> !wr_valid) else $error("write after load end");
  // No record passes after the end record
  ok_quiet_a: assert property (
    rec_ok |-> !load_done) else $error("record passed after load end");

  cover property (rec_ok);
  cover property ($rose(err_flag));
  cover property ($rose(load_done));
  cover property (wr_valid && !wr_ready);
endmodule : srec_chk

bind srecord_line_parser srec_chk u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .char_valid(char_valid),
  .char_data(char_data), .char_ready(char_ready), .wr_valid(wr_valid),
  .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready),
  .err_clear(err_clear), .load_restart(load_restart), .err_flag(err_flag),
  .err_cause(err_cause), .rec_ok(rec_ok), .load_done(load_done),
  .start_addr(start_addr)
);
`default_nettype wire

/* File: mem_loader_model.sv */
// Purpose: Target memory loader taking byte writes from the parser.
// Assumes: Valid/ready handshake on core_clk.
// Notes:   When slow is high, ready is drawn at random each cycle, high about one cycle in three.
`timescale 1ns/1ps
`default_nettype none
module mem_loader_model
  import srec_pkg::*;
(
  // Clock and stall control
  input  wire logic               core_clk,
  input  wire logic               slow,
  // Write port
  input  wire logic               wr_valid,
  input  wire logic [LOAD_AW-1:0] wr_addr,
  input  wire logic [7:0]         wr_data,
  output var  logic               wr_ready
);
  integer      seed = 32'h0000_5a5a; // Own stall stream
  logic [23:0] got[$];               // Writes taken, address then data

  initial wr_ready = 1'b1;
  // Log each taken write, then draw the next ready level
  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) begin
      got.push_back({wr_addr, wr_data});
    end
    wr_ready <= slow ? ({$random(seed)} % 3 == 0) : 1'b1;
  end
endmodule : mem_loader_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the load-record parser.
// Assumes: Fixed seed; writes land in the loader model.
// Notes:   Records and checksums are built here independently.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  import srec_pkg::*;
  logic               core_clk, arst_n, char_valid, err_clear, load_restart, slow;
  logic [7:0]         char_data, wr_data;
  logic               char_ready, wr_valid, wr_ready, err_flag, rec_ok, load_done;
  logic [LOAD_AW-1:0] wr_addr, start_addr;
  err_t               err_cause;
  integer             seed = 32'h1ff4_add0;
  int                 fails = 0, tests_run = 0, cyc = 0, ok_cnt = 0;
  logic [7:0]         rec_chars[$]; // Characters of the record being sent
  logic [23:0]        exp[$];       // Expected writes
  err_t               cause_tab[6] = '{ERR_SUM, ERR_CHAR, ERR_SHORT, ERR_LEN, ERR_TYPE, ERR_TYPE};

  srecord_line_parser dut (
    .core_clk(core_clk), .arst_n(arst_n), .char_valid(char_valid),
    .char_data(char_data), .char_ready(char_ready), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready),
    .err_clear(err_clear), .load_restart(load_restart), .err_flag(err_flag),
    .err_cause(err_cause), .rec_ok(rec_ok), .load_done(load_done),
    .start_addr(start_addr));
  mem_loader_model mem (.core_clk(core_clk), .slow(slow), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (rec_ok === 1'b1) ok_cnt++; // Passed records, one per pulse
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  // Hex digit character, either case
  function automatic logic [7:0] hx(input logic [3:0] n, input bit lc);
    return n < 10 ? 8'h30 + n : (lc ? 8'h57 : 8'h37) + n;
  endfunction : hx
  task automatic add_byte(input logic [7:0] b, input bit lc);
    rec_chars.push_back(hx(b[7:4], lc));
    rec_chars.push_back(hx(b[3:0], lc));
  endtask : add_byte
  // Line number, type, length, address, data, checksum, terminators
  task automatic build(input logic [7:0] dig, input logic [15:0] a, input int nd,
                       input logic [7:0] bad, input bit store);
    logic [7:0] sum, b, len;
    bit         lc;
    lc = $random(seed);
    len = 8'(nd + 3);
    rec_chars = {8'h31, 8'h30, 8'h20};
    rec_chars.push_back(ASC_S);
    rec_chars.push_back(dig);
    add_byte(len, lc);
    add_byte(a[15:8], lc);
    add_byte(a[7:0], lc);
    sum = len + a[15:8] + a[7:0];
    for (int i = 0; i < nd; i++) begin
      b = $random(seed);
      add_byte(b, lc);
      sum += b;
      if (store) exp.push_back({a + 16'(i), b});
    end
    add_byte(~sum ^ bad, lc);
    rec_chars.push_back(ASC_CR);
    rec_chars.push_back(ASC_LF);
    rec_chars.push_back(ASC_NUL);
  endtask : build
  // Offer characters back to back, holding each until taken
  task automatic send;
    foreach (rec_chars[i]) begin
      char_valid <= 1'b1;
      char_data  <= rec_chars[i];
      @(posedge core_clk);
      while (char_ready !== 1'b1) @(posedge core_clk);
    end
    char_valid <= 1'b0;
    @(posedge core_clk); // Let the idle level reach the parser before any next record
  endtask : send
  // Wait for replay to finish, then compare the writes
  task automatic settle(input string name);
    int n;
    n = 0;
    while (n < 600 && !(char_ready === 1'b1 && wr_valid === 1'b0
                        && mem.got.size() >= exp.size())) begin
      @(posedge core_clk);
      n++;
    end
    repeat (8) @(posedge core_clk);
    `CHK(mem.got.size(), exp.size())
    foreach (exp[i]) if (i < mem.got.size()) `CHK(mem.got[i], exp[i])
    mem.got.delete();
    exp.delete();
    $display("test %s done", name);
  endtask : settle
  task automatic pulse_clear;
    err_clear <= 1'b1;
    @(posedge core_clk);
    err_clear <= 1'b0;
    @(posedge core_clk);
  endtask : pulse_clear
  task final_report;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    arst_n = 1'b0;
    char_valid = 1'b0;
    char_data = 8'h00;
    err_clear = 1'b0;
    load_restart = 1'b0;
    slow = 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // Header and end records before any data record are ignored
    build(ASC_0, 16'h0000, 3, 8'h00, 1'b0);
    send();
    build(ASC_9, 16'h1234, 0, 8'h00, 1'b0);
    send();
    settle("pre");
    `CHK(load_done, 1'b0)
    `CHK(err_flag, 1'b0)
    // Random data records, empty and 28-byte ones first, stalls on odd ones
    for (int r = 0; r < 12; r++) begin
      slow <= r[0];
      build(ASC_1, 16'($random(seed)), r < 2 ? r * 28 : {$random(seed)} % 29, 8'h00, 1'b1);
      send();
      settle("data");
      `CHK(err_flag, 1'b0)
      `CHK(ok_cnt, r + 1)
    end
    // Faulty records: checksum, bad char, cut short, short length, bad types
    for (int k = 0; k < 6; k++) begin
      build(k < 4 ? ASC_1 : (k == 4 ? ASC_0 : 8'h35), 16'h0100, 4, 8'(k == 0), 1'b0);
      if (k == 1) rec_chars[12] = 8'h47;
      if (k == 2) rec_chars.delete(12);
      if (k == 2) rec_chars.delete(12);
      if (k == 3) rec_chars[6] = 8'h32;
      send();
      settle("fault");
      `CHK(err_flag, 1'b1)
      `CHK(err_cause, cause_tab[k])
      `CHK(ok_cnt, 12)
      pulse_clear();
      `CHK(err_flag, 1'b0)
    end
    // Address wraps across the top; then the end record
    build(ASC_1, 16'hfffe, 3, 8'h00, 1'b1);
    send();
    settle("wrap");
    build(ASC_9, 16'h4c00, 0, 8'h00, 1'b0);
    send();
    settle("end");
    `CHK(load_done, 1'b1)
    `CHK(start_addr, 16'h4c00)
    // Data after the end record is ignored
    build(ASC_1, 16'h0200, 2, 8'h00, 1'b0);
    send();
    settle("after");
    `CHK(load_done, 1'b1)
    `CHK(ok_cnt, 13)
    // Restart and load again
    load_restart <= 1'b1;
    @(posedge core_clk);
    load_restart <= 1'b0;
    @(posedge core_clk);
    `CHK(load_done, 1'b0)
    build(ASC_1, 16'h0300, 5, 8'h00, 1'b1);
    send();
    settle("restart");
    `CHK(ok_cnt, 14)
    final_report();
  end
endmodule : testbench
`undef CHK
`default_nettype wire
